// ===== usbo_ctrl.sv
// Summary of operation
// - Toggle-clear write zeroes the OUT data toggle
// - Stall-sent flag sets on STALL, firmware clears
// - Send-stall bit makes endpoint answer STALL
// - ISO bad packet sets error, release clears
// - Packet refused by full FIFO sets overrun
// - FIFO-full follows packets held versus capacity
// - New packet sets ready and interrupt flag
// - Low control byte resets zero, mixed access
// - Indexed registers banked by endpoint select
// - One FIFO window per endpoint zero to three
// - Separate flag and enable sets per group
// - Frame number split over low, high bytes
// - Count register shows control endpoint bytes
//
// Our own choice: the AHB-Lite slave port.
module usbo_ctrl
    import usbo_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire usbo_rx_t    rx,
    input  wire logic [3:0]  stall_ev,
    input  wire logic [3:0]  in_ev,
    input  wire logic [3:0]  common_ev,
    input  wire logic        sof,
    input  wire logic [10:0] frame_num,
    input  wire logic [7:0]  ctrl_rx_count,
    input  wire logic [31:0] fifo_head,
    output logic [7:0]       func_addr,
    output logic [3:0]       send_stall,
    output logic [3:0]       data_toggle,
    output logic [3:0]       fifo_pop,
    output logic [3:0]       fifo_push,
    output logic [7:0]       fifo_wdata,
    output logic             irq
);

    // Bus pipeline state
    logic        wr_pend_q;     // Write data phase pending
    logic        rd_pend_q;     // Read wait cycle pending
    logic [7:0]  idx_q;         // Latched register index
    logic        hreadyout_q;   // Ready towards master
    logic [31:0] hrdata_q;      // Read data
    // Common registers
    logic [7:0]  func_addr_q;   // Function bus address
    logic [7:0]  power_q;       // Power management
    logic [7:0]  clk_rec_q;     // Clock recovery control
    logic [7:0]  ep_sel_q;      // Endpoint select
    logic [7:0]  ctrl_csr_q;    // Control endpoint status
    logic [7:0]  frame_lo_q;    // Frame number low
    logic [7:0]  frame_hi_q;    // Frame number high
    logic [7:0]  ctrl_cnt_q;    // Control endpoint byte count
    logic [7:0]  in_csr_lo_q [NUM_EP]; // IN status low per bank
    logic [7:0]  in_csr_hi_q [NUM_EP]; // IN status high per bank
    // Interrupt flags and enables
    logic [7:0]  in_irq_q;      // IN and endpoint 0 flags
    logic [7:0]  out_irq_q;     // OUT endpoint flags
    logic [7:0]  cm_irq_q;      // Common event flags
    logic [7:0]  in_ie_q;       // IN enables
    logic [7:0]  out_ie_q;      // OUT enables
    logic [7:0]  cm_ie_q;       // Common enables
    logic        irq_q;         // Interrupt output
    // Strobe outputs
    logic [3:0]  fifo_pop_q;    // FIFO read strobes
    logic [3:0]  fifo_push_q;   // FIFO write strobes
    logic [7:0]  fifo_wdata_q;  // FIFO write byte
    logic [3:0]  send_stall_q;  // Stall requests
    logic [3:0]  toggle_q;      // Data toggles
    // Endpoint slices
    logic [7:0]  ep_lo   [NUM_EP];
    logic [7:0]  ep_hi   [NUM_EP];
    logic [1:0]  ep_cnt  [NUM_EP];
    logic [3:0]  ep_stall;
    logic [3:0]  ep_tog;
    logic [3:0]  ep_pkt;
    usbo_wr_t    ep_wr   [NUM_EP];
    // Decode
    logic        addr_ok;       // Address phase valid
    logic [7:0]  wbyte;         // Written byte
    logic [1:0]  bank;          // Selected endpoint
    logic [7:0]  rd_mux;        // Read value

    // Register index from a byte address
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        return a[9:2];
    endfunction : reg_index

    // Write strobe for one index
    function automatic logic wr_hit(input logic [7:0] idx);
        return wr_pend_q && (idx_q == idx);
    endfunction : wr_hit

    assign addr_ok = hsel && hready && htrans[1];
    assign wbyte   = hwdata[7:0];
    assign bank    = ep_sel_q[1:0];

    // Address phase capture, read wait cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_q   <= 1'b0;
            rd_pend_q   <= 1'b0;
            idx_q       <= RST_BYTE;
            hreadyout_q <= 1'b1;
        end else begin
            wr_pend_q   <= addr_ok && hwrite;
            rd_pend_q   <= addr_ok && !hwrite;
            hreadyout_q <= !(addr_ok && !hwrite);
            if (addr_ok) begin
                idx_q <= reg_index(haddr);
            end
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata_q <= RST_WORD;
        end else if (rd_pend_q) begin
            hrdata_q <= {24'h000000, rd_mux};
        end
    end

    // Common read/write registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            func_addr_q <= RST_BYTE;
            power_q     <= RST_BYTE;
            clk_rec_q   <= RST_BYTE;
            ep_sel_q    <= RST_BYTE;
            ctrl_csr_q  <= RST_BYTE;
            in_ie_q     <= RST_BYTE;
            out_ie_q    <= RST_BYTE;
            cm_ie_q     <= RST_BYTE;
        end else begin
            if (wr_hit(IDX_FUNC_ADDR)) func_addr_q <= wbyte;
            if (wr_hit(IDX_POWER))     power_q     <= wbyte;
            if (wr_hit(IDX_CLK_REC))   clk_rec_q   <= wbyte;
            if (wr_hit(IDX_EP_SEL))    ep_sel_q    <= wbyte;
            if (wr_hit(IDX_CTRL_CSR))  ctrl_csr_q  <= wbyte;
            if (wr_hit(IDX_IN_IE))     in_ie_q     <= wbyte;
            if (wr_hit(IDX_OUT_IE))    out_ie_q    <= wbyte;
            if (wr_hit(IDX_CM_IE))     cm_ie_q     <= wbyte;
        end
    end

    // Banked IN status bytes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_EP; i++) begin
                in_csr_lo_q[i] <= RST_BYTE;
                in_csr_hi_q[i] <= RST_BYTE;
            end
        end else begin
            if (wr_hit(IDX_IN_CSR_LO)) in_csr_lo_q[bank] <= wbyte;
            if (wr_hit(IDX_IN_CSR_HI)) in_csr_hi_q[bank] <= wbyte;
        end
    end

    // Frame number latched on start of frame
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_lo_q <= RST_BYTE;
            frame_hi_q <= RST_BYTE;
        end else if (sof) begin
            frame_lo_q <= frame_num[7:0];
            frame_hi_q <= {5'b00000, frame_num[10:8]};
        end
    end

    // Control endpoint received byte count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_cnt_q <= RST_BYTE;
        end else begin
            ctrl_cnt_q <= ctrl_rx_count;
        end
    end

    // Sticky flags; events win over clears
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_irq_q  <= RST_BYTE;
            out_irq_q <= RST_BYTE;
            cm_irq_q  <= RST_BYTE;
        end else begin
            in_irq_q  <= (in_irq_q & ~(wr_hit(IDX_IN_IRQ_CLR) ? wbyte : 8'h00))
                         | {4'h0, in_ev};
            out_irq_q <= (out_irq_q & ~(wr_hit(IDX_OUT_IRQ_CLR) ? wbyte : 8'h00))
                         | {4'h0, ep_pkt[3:1], 1'b0};
            cm_irq_q  <= (cm_irq_q & ~(wr_hit(IDX_CM_IRQ_CLR) ? wbyte : 8'h00))
                         | {4'h0, common_ev};
        end
    end

    // Single level interrupt output
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |{in_irq_q & in_ie_q, out_irq_q & out_ie_q, cm_irq_q & cm_ie_q};
        end
    end

    // FIFO window strobes, one address per endpoint
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fifo_pop_q   <= 4'h0;
            fifo_push_q  <= 4'h0;
            fifo_wdata_q <= RST_BYTE;
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                fifo_pop_q[i]  <= rd_pend_q && (idx_q == IDX_FIFO_BASE + 8'(i));
                fifo_push_q[i] <= wr_hit(IDX_FIFO_BASE + 8'(i));
            end
            if (wr_pend_q) begin
                fifo_wdata_q <= wbyte;
            end
        end
    end

    // Endpoint controls registered for the outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            send_stall_q <= 4'h0;
            toggle_q     <= 4'h0;
        end else begin
            send_stall_q <= ep_stall;
            toggle_q     <= ep_tog;
        end
    end

    // Per-endpoint OUT status slices, bank 0 unused
    assign ep_lo[0]  = RST_BYTE;
    assign ep_hi[0]  = RST_BYTE;
    assign ep_cnt[0] = 2'd0;
    assign ep_stall[0] = 1'b0;
    assign ep_tog[0]   = 1'b0;
    assign ep_pkt[0]   = 1'b0;
    assign ep_wr[0]    = '0;
    for (genvar g = 1; g < NUM_EP; g++) begin : g_ep
        assign ep_wr[g].wr_lo = wr_hit(IDX_OUT_CSR_LO) && (bank == 2'(g));
        assign ep_wr[g].wr_hi = wr_hit(IDX_OUT_CSR_HI) && (bank == 2'(g));
        assign ep_wr[g].data  = wbyte;
        usbo_out_ep u_ep (
            .clk        (clk),
            .reset_n    (reset_n),
            .wr         (ep_wr[g]),
            .rx_valid   (rx.valid && (rx.ep == 2'(g))),
            .rx_bad     (rx.bad),
            .stall_ev   (stall_ev[g]),
            .csr_lo     (ep_lo[g]),
            .csr_hi     (ep_hi[g]),
            .send_stall (ep_stall[g]),
            .toggle     (ep_tog[g]),
            .pkt_ev     (ep_pkt[g]),
            .pkt_cnt    (ep_cnt[g])
        );
    end

    // Read multiplexer over the latched index
    always_comb begin
        rd_mux = RST_BYTE;
        unique case (idx_q)
            IDX_FUNC_ADDR:  rd_mux = func_addr_q;
            IDX_POWER:      rd_mux = power_q;
            IDX_IN_IRQ:     rd_mux = in_irq_q;
            IDX_OUT_IRQ:    rd_mux = out_irq_q;
            IDX_CM_IRQ:     rd_mux = cm_irq_q;
            IDX_IN_IE:      rd_mux = in_ie_q;
            IDX_OUT_IE:     rd_mux = out_ie_q;
            IDX_CM_IE:      rd_mux = cm_ie_q;
            IDX_FRAME_LO:   rd_mux = frame_lo_q;
            IDX_FRAME_HI:   rd_mux = frame_hi_q;
            IDX_EP_SEL:     rd_mux = ep_sel_q;
            IDX_CLK_REC:    rd_mux = clk_rec_q;
            IDX_IN_CSR_LO:  rd_mux = in_csr_lo_q[bank];
            IDX_CTRL_CSR:   rd_mux = ctrl_csr_q;
            IDX_IN_CSR_HI:  rd_mux = in_csr_hi_q[bank];
            IDX_OUT_CNT_LO: rd_mux = {6'h00, ep_cnt[bank]};
            IDX_OUT_CSR_LO: rd_mux = ep_lo[bank];
            IDX_OUT_CSR_HI: rd_mux = ep_hi[bank];
            IDX_CTRL_CNT:   rd_mux = ctrl_cnt_q;
            IDX_FIFO_BASE:        rd_mux = fifo_head[7:0];
            IDX_FIFO_BASE + 8'd1: rd_mux = fifo_head[15:8];
            IDX_FIFO_BASE + 8'd2: rd_mux = fifo_head[23:16];
            IDX_FIFO_BASE + 8'd3: rd_mux = fifo_head[31:24];
            default:        rd_mux = RST_BYTE;
        endcase
    end

    assign hrdata      = hrdata_q;
    assign hreadyout   = hreadyout_q;
    assign hresp       = 1'b0;
    assign func_addr   = func_addr_q;
    assign send_stall  = send_stall_q;
    assign data_toggle = toggle_q;
    assign fifo_pop    = fifo_pop_q;
    assign fifo_push   = fifo_push_q;
    assign fifo_wdata  = fifo_wdata_q;
    assign irq         = irq_q;

endmodule : usbo_ctrl

// ===== usbo_pkg.sv
package usbo_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_FUNC_ADDR   = 8'h00;
    localparam logic [7:0] IDX_POWER       = 8'h01;
    localparam logic [7:0] IDX_IN_IRQ      = 8'h02;
    localparam logic [7:0] IDX_IN_IRQ_CLR  = 8'h03;
    localparam logic [7:0] IDX_OUT_IRQ     = 8'h04;
    localparam logic [7:0] IDX_OUT_IRQ_CLR = 8'h05;
    localparam logic [7:0] IDX_CM_IRQ      = 8'h06;
    localparam logic [7:0] IDX_IN_IE       = 8'h07;
    localparam logic [7:0] IDX_CM_IRQ_CLR  = 8'h08;
    localparam logic [7:0] IDX_OUT_IE      = 8'h09;
    localparam logic [7:0] IDX_CM_IE       = 8'h0B;
    localparam logic [7:0] IDX_FRAME_LO    = 8'h0C;
    localparam logic [7:0] IDX_FRAME_HI    = 8'h0D;
    localparam logic [7:0] IDX_EP_SEL      = 8'h0E;
    localparam logic [7:0] IDX_CLK_REC     = 8'h0F;
    localparam logic [7:0] IDX_IN_CSR_LO   = 8'h10;
    localparam logic [7:0] IDX_CTRL_CSR    = 8'h11;
    localparam logic [7:0] IDX_IN_CSR_HI   = 8'h12;
    localparam logic [7:0] IDX_OUT_CNT_LO  = 8'h13;
    localparam logic [7:0] IDX_OUT_CSR_LO  = 8'h14;
    localparam logic [7:0] IDX_OUT_CSR_HI  = 8'h15;
    localparam logic [7:0] IDX_CTRL_CNT    = 8'h16;
    localparam logic [7:0] IDX_OUT_CNT_HI  = 8'h17;
    localparam logic [7:0] IDX_FIFO_BASE   = 8'h20;
    localparam int         NUM_EP          = 4;

    // OUT control low byte fields
    localparam int BIT_TOGGLE_CLEAR = 7;
    localparam int BIT_STALL_SENT   = 6;
    localparam int BIT_SEND_STALL   = 5;
    localparam int BIT_FLUSH        = 4;
    localparam int BIT_ISO_DATA_ERR = 3;
    localparam int BIT_OVERRUN      = 2;
    localparam int BIT_FIFO_FULL    = 1;
    localparam int BIT_PKT_READY    = 0;
    // OUT control high byte fields
    localparam int BIT_DOUBLE_BUF   = 7;
    localparam int BIT_ISO_MODE     = 6;

    // Reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;

    // Received packet report from the serial engine
    typedef struct packed {
        logic       valid;  // One-cycle pulse, packet ended
        logic [1:0] ep;     // Endpoint number
        logic       bad;    // CRC or bit-stuffing error
    } usbo_rx_t;

    // Register write strobe towards one endpoint
    typedef struct packed {
        logic       wr_lo;  // Write to OUT control low
        logic       wr_hi;  // Write to OUT control high
        logic [7:0] data;   // Written byte
    } usbo_wr_t;

endpackage : usbo_pkg

// ===== usbo_out_ep.sv
module usbo_out_ep
    import usbo_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     reset_n,
    input  wire usbo_wr_t wr,
    input  wire logic     rx_valid,
    input  wire logic     rx_bad,
    input  wire logic     stall_ev,
    output logic [7:0]    csr_lo,
    output logic [7:0]    csr_hi,
    output logic          send_stall,
    output logic          toggle,
    output logic          pkt_ev,
    output logic [1:0]    pkt_cnt
);

    logic       stall_sent_q;  // Sticky stall-sent flag
    logic       send_stall_q;  // Stall request
    logic       flush_q;       // Flush in progress
    logic       data_err_q;    // ISO data error
    logic       overrun_q;     // Lost packet flag
    logic       toggle_q;      // Data toggle
    logic       pkt_ev_q;      // Packet accepted pulse
    logic [7:0] hi_q;          // High control byte
    logic [1:0] cnt_q;         // Packets held
    logic [1:0] cap;           // Packets that fit
    logic       full;          // FIFO holds its capacity
    logic       iso;           // Isochronous mode
    logic       accept;        // Packet goes into FIFO
    logic       lost;          // Packet refused
    logic       release_pkt;   // Firmware frees a packet
    logic       flush_done;    // Flush drops a packet

    // Capacity and status decode
    assign cap         = hi_q[BIT_DOUBLE_BUF] ? 2'd2 : 2'd1;
    assign full        = (cnt_q >= cap);
    assign iso         = hi_q[BIT_ISO_MODE];
    assign lost        = rx_valid && (!rx_bad || iso) && full;
    assign accept      = rx_valid && (!rx_bad || iso) && !full;
    assign release_pkt = wr.wr_lo && !wr.data[BIT_PKT_READY] && (cnt_q != 2'd0);
    assign flush_done  = flush_q && (cnt_q != 2'd0) && !release_pkt;

    // Packet count, up on accept, down on release or flush
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 2'd0;
        end else begin
            cnt_q <= cnt_q + 2'(accept) - 2'(release_pkt) - 2'(flush_done);
        end
    end

    // Flush bit, cleared by hardware the cycle after it is set
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flush_q <= 1'b0;
        end else if (wr.wr_lo && wr.data[BIT_FLUSH]) begin
            flush_q <= 1'b1;
        end else begin
            flush_q <= 1'b0;
        end
    end

    // Stall-sent flag; a new stall beats a clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stall_sent_q <= 1'b0;
        end else if (stall_ev) begin
            stall_sent_q <= 1'b1;
        end else if (wr.wr_lo) begin
            stall_sent_q <= wr.data[BIT_STALL_SENT] & stall_sent_q;
        end
    end

    // Send-stall request under firmware control
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            send_stall_q <= 1'b0;
        end else if (wr.wr_lo) begin
            send_stall_q <= wr.data[BIT_SEND_STALL];
        end
    end

    // ISO data error, cleared by packet release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_err_q <= 1'b0;
        end else if (accept && rx_bad) begin
            data_err_q <= 1'b1;
        end else if (release_pkt) begin
            data_err_q <= 1'b0;
        end
    end

    // Overrun flag; a lost packet beats a clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_q <= 1'b0;
        end else if (lost) begin
            overrun_q <= 1'b1;
        end else if (wr.wr_lo) begin
            overrun_q <= wr.data[BIT_OVERRUN] & overrun_q;
        end
    end

    // Data toggle, zeroed on toggle-clear write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            toggle_q <= 1'b0;
        end else if (wr.wr_lo && wr.data[BIT_TOGGLE_CLEAR]) begin
            toggle_q <= 1'b0;
        end else if (accept) begin
            toggle_q <= ~toggle_q;
        end
    end

    // Packet-ready event towards the interrupt flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pkt_ev_q <= 1'b0;
        end else begin
            pkt_ev_q <= accept;
        end
    end

    // High control byte, plain storage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_q <= RST_BYTE;
        end else if (wr.wr_hi) begin
            hi_q <= wr.data;
        end
    end

    // Low byte view; toggle-clear reads zero
    always_comb begin
        csr_lo                   = RST_BYTE;
        csr_lo[BIT_STALL_SENT]   = stall_sent_q;
        csr_lo[BIT_SEND_STALL]   = send_stall_q;
        csr_lo[BIT_FLUSH]        = flush_q;
        csr_lo[BIT_ISO_DATA_ERR] = data_err_q;
        csr_lo[BIT_OVERRUN]      = overrun_q;
        csr_lo[BIT_FIFO_FULL]    = full;
        csr_lo[BIT_PKT_READY]    = (cnt_q != 2'd0);
    end

    assign csr_hi     = hi_q;
    assign send_stall = send_stall_q;
    assign toggle     = toggle_q;
    assign pkt_ev     = pkt_ev_q;
    assign pkt_cnt    = cnt_q;

endmodule : usbo_out_ep

// ===== usbo_host_model.sv
module usbo_host_model
    import usbo_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       go,
    input  wire logic       stl,
    input  wire logic [1:0] ep,
    input  wire logic       bad,
    output usbo_rx_t        rx,
    output logic [3:0]      stall_ev
);
    // Packet end and STALL reports, one cycle each
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx       <= '0;
            stall_ev <= 4'h0;
        end else begin
            rx       <= '{valid: go, ep: ep, bad: bad};
            stall_ev <= stl ? 4'h1 << ep : 4'h0;
        end
    end
endmodule : usbo_host_model

// ===== usbo_ctrl_checker.sv
module usbo_ctrl_checker
    import usbo_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [7:0]  ctrl_rx_count,
    input wire logic [3:0]  send_stall,
    input wire logic [3:0]  data_toggle,
    input wire logic [3:0]  fifo_pop,
    input wire logic [3:0]  fifo_push,
    input wire logic [7:0]  fifo_wdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic       tk;                     // Transfer taken
    logic       wv_q, lo_q, fw_q, fr_q; // Phase trackers
    logic [7:0] wi_q, d_q;              // Write index, data
    logic [1:0] bank_q, fi_q, fp_q;     // Bank, FIFO numbers
    assign tk = hsel && hready && htrans[1];
    // Follow address and data phases
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {wv_q, lo_q, fw_q, fr_q} <= 4'h0;
            bank_q <= 2'h0;
        end else begin
            wv_q <= tk && hwrite;
            wi_q <= haddr[9:2];
            fr_q <= tk && !hwrite && haddr[9:4] == IDX_FIFO_BASE[7:2];
            lo_q <= wv_q && wi_q == IDX_OUT_CSR_LO;
            fw_q <= wv_q && wi_q[7:2] == IDX_FIFO_BASE[7:2];
            if (wv_q) d_q <= hwdata[7:0];
            if (wv_q) fp_q <= wi_q[1:0];
            if (tk && !hwrite) fi_q <= haddr[3:2];
            if (wv_q && wi_q == IDX_EP_SEL) bank_q <= hwdata[1:0];
        end
    end
    sequence rd_s;
        tk && !hwrite;
    endsequence
    sequence cnt_rd_s;
        rd_s and haddr[9:2] == IDX_CTRL_CNT;
    endsequence
    read_wait_a: assert property (rd_s |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_fast_a: assert property (tk && hwrite |=> hreadyout)
        else $error("write stalled");
    resp_okay_a: assert property (hresp == 1'h0)
        else $error("response not okay");
    count_read_a: assert property (cnt_rd_s |-> ##2 hrdata == {24'h0, ctrl_rx_count})
        else $error("count read wrong");
    send_stall_a: assert property (lo_q && bank_q != 2'h0
        |-> ##[1:2] send_stall[bank_q] == d_q[5])
        else $error("stall output wrong");
    toggle_clear_a: assert property (lo_q && bank_q != 2'h0 && d_q[7]
        |-> ##[1:2] !data_toggle[bank_q])
        else $error("toggle not cleared");
    bank_zero_a: assert property (!send_stall[0] && !data_toggle[0])
        else $error("bank zero driven");
    fifo_pop_a: assert property (fr_q |-> ##[1:3] fifo_pop == 4'h1 << fi_q)
        else $error("pop missing");
    fifo_push_a: assert property (fw_q
        |-> ##[0:1] fifo_push == 4'h1 << fp_q && fifo_wdata == d_q)
        else $error("push wrong");
endmodule : usbo_ctrl_checker
bind usbo_ctrl usbo_ctrl_checker chk_u (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .ctrl_rx_count, .send_stall,
    .data_toggle, .fifo_pop, .fifo_push, .fifo_wdata);

// ===== usbo_ctrl_tb.sv
module usbo_ctrl_tb
    import usbo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic        sof = 1'h0, go = 1'h0, stl = 1'h0, gbad = 1'h0;
    logic [1:0]  htrans = 2'h0, gep = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [31:0] fifo_head = 32'hD4C3B2A1;
    logic [3:0]  in_ev = 4'h0, common_ev = 4'h0;
    logic [10:0] frame_num = 11'h5A3;
    logic [7:0]  ctrl_rx_count = 8'h2C;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, irq;
    wire  [3:0]  stall_ev, send_stall, data_toggle, fifo_pop, fifo_push;
    wire  [7:0]  func_addr, fifo_wdata;
    wire usbo_rx_t rx;
    int          num_errors = 0, total_checks = 0;
    usbo_ctrl dut_u (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx, .stall_ev, .in_ev,
        .common_ev, .sof, .frame_num, .ctrl_rx_count, .fifo_head, .func_addr,
        .send_stall, .data_toggle, .fifo_pop, .fifo_push, .fifo_wdata, .irq);
    usbo_host_model host_u (.clk, .reset_n, .go, .stl, .ep(gep), .bad(gbad), .rx, .stall_ev);
    initial forever #50 clk = ~clk;
    // One single AHB transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        hsel   <= 1'h1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask : ahb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        ahb(1'h0, idx, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rdc
    // Host sends a packet, or reports a sent STALL
    task automatic host(input logic s, input logic b);
        go   <= !s;
        stl  <= s;
        gep  <= 2'h1;
        gbad <= b;
        @(posedge clk);
        go  <= 1'h0;
        stl <= 1'h0;
        repeat (3) @(posedge clk);
    endtask : host
    // Reset value, stall control, count, FIFO window
    task automatic s_regs;
        ahb(1'h1, IDX_EP_SEL, 8'h01);
        rdc(IDX_OUT_CSR_LO, 8'h00);
        ahb(1'h1, IDX_OUT_CSR_LO, 8'hA0);
        rdc(IDX_OUT_CSR_LO, 8'h20);
        chk({28'h0, send_stall}, 32'h2);
        ahb(1'h1, IDX_OUT_CSR_LO, 8'h00);
        rdc(IDX_OUT_CSR_LO, 8'h00);
        rdc(8'h30, 8'h00);
        rdc(IDX_CTRL_CNT, 8'h2C);
        rdc(IDX_FIFO_BASE + 8'h01, 8'hB2);
        ahb(1'h1, IDX_FIFO_BASE + 8'h03, 8'h5E);
        host(1'h1, 1'h0);
        rdc(IDX_OUT_CSR_LO, 8'h40);
        ahb(1'h1, IDX_OUT_CSR_LO, 8'h00);
        rdc(IDX_OUT_CSR_LO, 8'h00);
    endtask : s_regs
    // Ready, full, overrun, interrupt, toggle, flush
    task automatic s_pkt;
        ahb(1'h1, IDX_OUT_IE, 8'h02);
        host(1'h0, 1'h0);
        rdc(IDX_OUT_CSR_LO, 8'h03);
        chk({31'h0, irq}, 32'h1);
        chk({28'h0, data_toggle}, 32'h2);
        host(1'h0, 1'h0);
        rdc(IDX_OUT_CSR_LO, 8'h07);
        ahb(1'h1, IDX_OUT_CSR_LO, 8'h87);
        rdc(IDX_OUT_IRQ, 8'h02);
        chk({28'h0, data_toggle}, 32'h0);
        ahb(1'h1, IDX_OUT_IRQ_CLR, 8'h02);
        rdc(IDX_OUT_IRQ, 8'h00);
        chk({31'h0, irq}, 32'h0);
        ahb(1'h1, IDX_OUT_IE, 8'h00);
        ahb(1'h1, IDX_OUT_CSR_LO, 8'h00);
        rdc(IDX_OUT_CSR_LO, 8'h00);
        host(1'h0, 1'h0);
        rdc(IDX_OUT_IRQ, 8'h02);
        chk({31'h0, irq}, 32'h0);
        ahb(1'h1, IDX_OUT_CSR_LO, 8'h11);
        rdc(IDX_OUT_CSR_LO, 8'h00);
    endtask : s_pkt
    // Bad isochronous packet, banking, frame number
    task automatic s_iso;
        ahb(1'h1, IDX_OUT_CSR_HI, 8'hC0);
        host(1'h0, 1'h1);
        rdc(IDX_OUT_CSR_LO, 8'h09);
        host(1'h0, 1'h0);
        rdc(IDX_OUT_CSR_LO, 8'h0B);
        ahb(1'h1, IDX_EP_SEL, 8'h02);
        rdc(IDX_OUT_CSR_LO, 8'h00);
        ahb(1'h1, IDX_EP_SEL, 8'h01);
        ahb(1'h1, IDX_OUT_CSR_LO, 8'h00);
        rdc(IDX_OUT_CSR_LO, 8'h01);
        sof <= 1'h1;
        in_ev <= 4'h4;
        @(posedge clk);
        sof <= 1'h0;
        in_ev <= 4'h0;
        rdc(IDX_IN_IRQ, 8'h04);
        rdc(IDX_FRAME_LO, 8'hA3);
        rdc(IDX_FRAME_HI, 8'h05);
    endtask : s_iso
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        s_regs;
        s_pkt;
        s_iso;
        end_of_test;
    end
    // Watchdog against a hung handshake
    initial begin
        #2_000_000;
        num_errors++;
        end_of_test;
    end
endmodule : usbo_ctrl_tb
